/* include/panel_pkg.sv */
package panel_pkg;
    // Timing
    localparam int CLK_PERIOD_NS = 10;
    localparam int SECOND_NS = 1000000000;
    localparam int SECOND_CYCLES = SECOND_NS / CLK_PERIOD_NS;
    localparam int DUR_STEP_S = 5;
    localparam int MINUTE_S = 60;
    localparam int CNT_W = 11;

    // Stored time limits and defaults
    localparam logic [6:0] DUR_MAX = 7'h63;
    localparam logic [6:0] DUR_RESET = 7'h02;
    localparam logic [5:0] DELAY_MAX = 6'h3C;
    localparam logic [5:0] DELAY_RESET = 6'h3C;
    localparam logic [4:0] HOLD_MAX = 5'h1E;
    localparam logic [4:0] HOLD_RESET = 5'h1E;

    // Front-panel inputs, index into the synchronised vector
    localparam int NUM_BTN = 6;
    localparam int BTN_INC = 0;
    localparam int BTN_DEC = 1;
    localparam int BTN_SCROLL = 2;
    localparam int BTN_TOGGLE = 3;
    localparam int BTN_RESET = 4;
    localparam int BTN_PRG = 5;

    // Disable menu items: three zones and the first siren
    localparam int NUM_ZONES = 3;
    localparam int NUM_ITEMS = 4;
    localparam logic [1:0] ITEM_FIRST = 2'h0;
    localparam logic [1:0] ITEM_SIREN = 2'h3;

    // Register map
    localparam int ADDR_W = 8;
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_TIMES = 8'h04;
    localparam logic [7:0] ADDR_STATUS = 8'h08;
    localparam int CTRL_LEVEL2_BIT = 0;
    localparam int ST_PROG_BIT = 0;
    localparam int ST_MENU_BIT = 1;
    localparam int ST_SEL_LSB = 2;
    localparam int ST_DIS_LSB = 4;
    localparam int ST_SEQ_LSB = 8;
    localparam int ST_DISCH_BIT = 10;
    localparam int ST_LOCK_BIT = 11;
    localparam logic [31:0] RDATA_ZERO = 32'h0000_0000;

    typedef enum logic [1:0] {
        SEL_DUR = 2'b00,
        SEL_DELAY = 2'b01,
        SEL_HOLD = 2'b11
    } prog_sel_t;

    typedef enum logic [1:0] {
        SEQ_IDLE = 2'b00,
        SEQ_DELAY = 2'b01,
        SEQ_DISCHARGE = 2'b11,
        SEQ_HOLD = 2'b10
    } seq_state_t;

    typedef struct packed {
        logic [6:0] dur;
        logic [5:0] delay;
        logic [4:0] hold;
    } times_t;

    localparam times_t TIMES_RESET = '{dur: DUR_RESET, delay: DELAY_RESET, hold: HOLD_RESET};
endpackage

/* hw/button_edge.sv */
`timescale 1ns/100ps
module button_edge #(
    parameter int N = 1
) (
    // Clock and reset
    input wire logic sys_clk_in,
    input wire logic srst_in,
    // Raw contacts
    input wire logic [N-1:0] raw_in,
    // Synchronised level and press pulse
    output logic [N-1:0] level_out,
    output logic [N-1:0] rise_out
);
    genvar i;
    generate
        for (i = 0; i < N; i++)
        begin : g_bit
            logic meta_q;
            logic sync_q;
            logic prev_q;
            always_ff @(posedge sys_clk_in)
            begin
                if (srst_in)
                begin
                    meta_q <= 1'b0;
                    sync_q <= 1'b0;
                    prev_q <= 1'b0;
                    rise_out[i] <= 1'b0;
                end
                else
                begin
                    meta_q <= raw_in[i];
                    sync_q <= meta_q;
                    prev_q <= sync_q;
                    rise_out[i] <= sync_q & ~prev_q;
                end
            end
            assign level_out[i] = sync_q;
        end
    endgenerate
endmodule

/* hw/tick_gen.sv */
`timescale 1ns/100ps
module tick_gen #(
    parameter int unsigned CYCLES = 100
) (
    // Clock and reset
    input wire logic sys_clk_in,
    input wire logic srst_in,
    // Restart the period
    input wire logic clr_in,
    // One-cycle pulse every CYCLES cycles
    output logic tick_out
);
    logic [31:0] count_q;

    always_ff @(posedge sys_clk_in)
    begin
        if (srst_in || clr_in)
        begin
            count_q <= {31'h0000_0000, clr_in};
            tick_out <= 1'b0;
        end
        else
        begin
            tick_out <= (count_q == CYCLES - 1);
            count_q <= (count_q == CYCLES - 1) ? 32'h0000_0000 : count_q + 32'h0000_0001;
        end
    end
endmodule

/* hw/panel_settings.sv */
// The address map and the AHB-Lite register port were decided locally.
`timescale 1ns/100ps
// Summary of operation
// - Switch on enters programming, display lit
// - Scroll cycles duration, delay, hold, wraps
// - Switch off commits all times, leaves
// - Duration 0..99 units of 5 s, default 2
// - Buzzer-mute adds, siren-mute subtracts one unit
// - Delay 0..60 s, default 60, 1 s steps
// - Hold 0..30 min, default 30, 1 min steps
// - Delay starts at activation, then discharge
// - Reset refused from discharge until hold time elapsed
// - Discharge active exactly the stored duration
// - Disable menu needs access level 2
// - Menu: disable LED blinks, item shows state
// - Opens on zone 1, scroll steps items
// - Toggle inverts selected item's enable
// - Reset closes menu, commits, steady indicators
// - Disabled zones' inputs are ignored
// - Power-up reset clears all disablements
// - Menu entry refused during any fire alarm
// - Fire alarm aborts open menu at once
// - Second siren has no menu position
// - Selected first siren LED blinks, lit steady once disabled
module panel_settings #(
    parameter int unsigned TICK_CYCLES = panel_pkg::SECOND_CYCLES
) (
    // Clock and reset
    input wire logic sys_clk_in,
    input wire logic srst_in,
    // AHB-Lite slave
    input wire logic hsel_in,
    input wire logic [31:0] haddr_in,
    input wire logic [1:0] htrans_in,
    input wire logic hwrite_in,
    input wire logic [2:0] hsize_in,
    input wire logic [31:0] hwdata_in,
    input wire logic hready_in,
    output logic [31:0] hrdata_out,
    output logic hreadyout_out,
    output logic hresp_out,
    // Front-panel controls
    input wire logic program_switch_in,
    input wire logic buzzer_mute_button_in,
    input wire logic siren_mute_button_in,
    input wire logic scroll_button_in,
    input wire logic toggle_button_in,
    input wire logic reset_button_in,
    // Alarm side
    input wire logic [2:0] zone_fire_in,
    input wire logic activated_in,
    output logic [2:0] zone_alarm_out,
    output logic first_siren_enable_out,
    output logic discharge_out,
    output logic reset_accept_out,
    // Indicators
    output logic display_on_out,
    output logic [1:0] display_sel_out,
    output logic [6:0] display_value_out,
    output logic disable_led_out,
    output logic [2:0] zone_led_out,
    output logic siren_fault_led_out
);
    logic [panel_pkg::NUM_BTN-1:0] btn_raw;
    logic [panel_pkg::NUM_BTN-1:0] btn_lvl;
    logic [panel_pkg::NUM_BTN-1:0] btn_rise;
    logic sec_tick;
    logic tick_clr;
    logic blink_q;
    logic prog_q;
    panel_pkg::prog_sel_t prog_sel_q;
    panel_pkg::times_t work_q;
    panel_pkg::times_t stored_q;
    logic menu_q;
    logic [1:0] menu_sel_q;
    logic [panel_pkg::NUM_ITEMS-1:0] pend_q;
    logic [panel_pkg::NUM_ITEMS-1:0] dis_q;
    logic level2_q;
    logic fire_any;
    logic menu_open;
    panel_pkg::seq_state_t seq_q;
    panel_pkg::seq_state_t seq_d;
    logic [panel_pkg::CNT_W-1:0] cnt_q;
    logic [panel_pkg::CNT_W-1:0] cnt_d;
    logic act_prev_q;
    logic expired;
    logic locked;
    logic reset_ok;
    logic ap_valid;
    logic wr_pend_q;
    logic [panel_pkg::ADDR_W-1:0] wr_addr_q;
    logic [31:0] rd_mux;

    assign btn_raw = {program_switch_in, reset_button_in, toggle_button_in,
                      scroll_button_in, siren_mute_button_in, buzzer_mute_button_in};

    button_edge #(
        .N(panel_pkg::NUM_BTN)
    ) u_btn (
        .sys_clk_in(sys_clk_in),
        .srst_in(srst_in),
        .raw_in(btn_raw),
        .level_out(btn_lvl),
        .rise_out(btn_rise)
    );

    tick_gen #(
        .CYCLES(TICK_CYCLES)
    ) u_tick (
        .sys_clk_in(sys_clk_in),
        .srst_in(srst_in),
        .clr_in(tick_clr),
        .tick_out(sec_tick)
    );

    always_ff @(posedge sys_clk_in)
    begin
        if (srst_in)
            blink_q <= 1'b0;
        else if (sec_tick)
            blink_q <= ~blink_q;
    end

    // Programming mode
    always_ff @(posedge sys_clk_in)
    begin
        if (srst_in)
            prog_q <= 1'b0;
        else if (!prog_q && btn_lvl[panel_pkg::BTN_PRG] && !menu_q)
            prog_q <= 1'b1;
        else if (prog_q && !btn_lvl[panel_pkg::BTN_PRG])
            prog_q <= 1'b0;
    end

    always_ff @(posedge sys_clk_in)
    begin
        if (srst_in || !prog_q)
            prog_sel_q <= panel_pkg::SEL_DUR;
        else if (btn_rise[panel_pkg::BTN_SCROLL])
        begin
            unique case (prog_sel_q)
                panel_pkg::SEL_DUR: prog_sel_q <= panel_pkg::SEL_DELAY;
                panel_pkg::SEL_DELAY: prog_sel_q <= panel_pkg::SEL_HOLD;
                panel_pkg::SEL_HOLD: prog_sel_q <= panel_pkg::SEL_DUR;
                default: prog_sel_q <= panel_pkg::SEL_DUR;
            endcase
        end
    end

    // Working copy edited live, saturating at the limits
    always_ff @(posedge sys_clk_in)
    begin
        if (srst_in)
            work_q <= panel_pkg::TIMES_RESET;
        else if (!prog_q)
            work_q <= stored_q;
        else if (btn_rise[panel_pkg::BTN_INC])
        begin
            unique case (prog_sel_q)
                panel_pkg::SEL_DUR:
                    if (work_q.dur != panel_pkg::DUR_MAX)
                        work_q.dur <= work_q.dur + 7'h01;
                panel_pkg::SEL_DELAY:
                    if (work_q.delay != panel_pkg::DELAY_MAX)
                        work_q.delay <= work_q.delay + 6'h01;
                panel_pkg::SEL_HOLD:
                    if (work_q.hold != panel_pkg::HOLD_MAX)
                        work_q.hold <= work_q.hold + 5'h01;
                default: work_q <= work_q;
            endcase
        end
        else if (btn_rise[panel_pkg::BTN_DEC])
        begin
            unique case (prog_sel_q)
                panel_pkg::SEL_DUR:
                    if (work_q.dur != 7'h00)
                        work_q.dur <= work_q.dur - 7'h01;
                panel_pkg::SEL_DELAY:
                    if (work_q.delay != 6'h00)
                        work_q.delay <= work_q.delay - 6'h01;
                panel_pkg::SEL_HOLD:
                    if (work_q.hold != 5'h00)
                        work_q.hold <= work_q.hold - 5'h01;
                default: work_q <= work_q;
            endcase
        end
    end

    always_ff @(posedge sys_clk_in)
    begin
        if (srst_in)
            stored_q <= panel_pkg::TIMES_RESET;
        else if (prog_q && !btn_lvl[panel_pkg::BTN_PRG])
            stored_q <= work_q;
    end

    // Disable menu
    assign fire_any = |(zone_fire_in & ~dis_q[panel_pkg::NUM_ZONES-1:0]);
    assign menu_open = !menu_q && !prog_q && level2_q
                       && btn_rise[panel_pkg::BTN_TOGGLE] && !fire_any;

    always_ff @(posedge sys_clk_in)
    begin
        if (srst_in)
            menu_q <= 1'b0;
        else if (menu_open)
            menu_q <= 1'b1;
        else if (menu_q && (fire_any || btn_rise[panel_pkg::BTN_RESET]))
            menu_q <= 1'b0;
    end

    always_ff @(posedge sys_clk_in)
    begin
        if (srst_in || menu_open)
            menu_sel_q <= panel_pkg::ITEM_FIRST;
        else if (menu_q && btn_rise[panel_pkg::BTN_SCROLL])
            menu_sel_q <= (menu_sel_q == panel_pkg::ITEM_SIREN) ? panel_pkg::ITEM_FIRST
                          : menu_sel_q + 2'h1;
    end

    always_ff @(posedge sys_clk_in)
    begin
        if (srst_in)
            pend_q <= '0;
        else if (menu_open)
            pend_q <= dis_q;
        else if (menu_q && btn_rise[panel_pkg::BTN_TOGGLE])
            pend_q[menu_sel_q] <= ~pend_q[menu_sel_q];
    end

    always_ff @(posedge sys_clk_in)
    begin
        if (srst_in)
            dis_q <= '0;
        else if (menu_q && !fire_any && btn_rise[panel_pkg::BTN_RESET])
            dis_q <= pend_q;
    end

    // Release sequencer, counts in whole seconds
    assign expired = (cnt_q == '0) || (sec_tick && cnt_q == 11'h001);
    assign locked = (seq_q == panel_pkg::SEQ_DISCHARGE)
                    || (seq_q == panel_pkg::SEQ_HOLD && cnt_q != '0);
    assign reset_ok = btn_rise[panel_pkg::BTN_RESET] && !menu_q && !locked;

    always_comb
    begin
        seq_d = seq_q;
        cnt_d = (sec_tick && cnt_q != '0) ? cnt_q - 11'h001 : cnt_q;
        unique case (seq_q)
            panel_pkg::SEQ_IDLE:
                if (activated_in && !act_prev_q)
                begin
                    seq_d = panel_pkg::SEQ_DELAY;
                    cnt_d = {5'h00, stored_q.delay};
                end
            panel_pkg::SEQ_DELAY:
                if (reset_ok)
                    seq_d = panel_pkg::SEQ_IDLE;
                else if (expired && stored_q.dur == '0)
                begin
                    seq_d = panel_pkg::SEQ_HOLD;
                    cnt_d = 11'(stored_q.hold * panel_pkg::MINUTE_S);
                end
                else if (expired)
                begin
                    seq_d = panel_pkg::SEQ_DISCHARGE;
                    cnt_d = 11'(stored_q.dur * panel_pkg::DUR_STEP_S);
                end
            panel_pkg::SEQ_DISCHARGE:
                if (sec_tick && cnt_q == 11'h001)
                begin
                    seq_d = panel_pkg::SEQ_HOLD;
                    cnt_d = 11'(stored_q.hold * panel_pkg::MINUTE_S);
                end
            panel_pkg::SEQ_HOLD:
                if (reset_ok)
                    seq_d = panel_pkg::SEQ_IDLE;
        endcase
    end

    // Realign the second tick on every state change
    assign tick_clr = (seq_d != seq_q);

    always_ff @(posedge sys_clk_in)
    begin
        if (srst_in)
        begin
            seq_q <= panel_pkg::SEQ_IDLE;
            cnt_q <= '0;
            act_prev_q <= 1'b0;
            discharge_out <= 1'b0;
            reset_accept_out <= 1'b0;
        end
        else
        begin
            seq_q <= seq_d;
            cnt_q <= cnt_d;
            act_prev_q <= activated_in;
            discharge_out <= (seq_d == panel_pkg::SEQ_DISCHARGE);
            reset_accept_out <= reset_ok;
        end
    end

    // Alarm-side masking
    always_ff @(posedge sys_clk_in)
    begin
        if (srst_in)
        begin
            zone_alarm_out <= '0;
            first_siren_enable_out <= 1'b1;
        end
        else
        begin
            zone_alarm_out <= zone_fire_in & ~dis_q[panel_pkg::NUM_ZONES-1:0];
            first_siren_enable_out <= ~dis_q[panel_pkg::ITEM_SIREN];
        end
    end

    // Seven-segment display
    always_ff @(posedge sys_clk_in)
    begin
        if (srst_in)
        begin
            display_on_out <= 1'b0;
            display_sel_out <= panel_pkg::SEL_DUR;
            display_value_out <= '0;
        end
        else
        begin
            display_on_out <= prog_q;
            display_sel_out <= prog_sel_q;
            unique case (prog_sel_q)
                panel_pkg::SEL_DUR: display_value_out <= work_q.dur;
                panel_pkg::SEL_DELAY: display_value_out <= {1'b0, work_q.delay};
                panel_pkg::SEL_HOLD: display_value_out <= {2'h0, work_q.hold};
                default: display_value_out <= '0;
            endcase
        end
    end

    // Disable indicators
    always_ff @(posedge sys_clk_in)
    begin
        if (srst_in)
        begin
            disable_led_out <= 1'b0;
            siren_fault_led_out <= 1'b0;
        end
        else if (menu_q)
        begin
            disable_led_out <= blink_q;
            siren_fault_led_out <= (menu_sel_q == panel_pkg::ITEM_SIREN)
                                   ? (pend_q[panel_pkg::ITEM_SIREN] | blink_q)
                                   : pend_q[panel_pkg::ITEM_SIREN];
        end
        else
        begin
            disable_led_out <= |dis_q;
            siren_fault_led_out <= dis_q[panel_pkg::ITEM_SIREN];
        end
    end

    genvar z;
    generate
        for (z = 0; z < panel_pkg::NUM_ZONES; z++)
        begin : g_zone_led
            always_ff @(posedge sys_clk_in)
            begin
                if (srst_in)
                    zone_led_out[z] <= 1'b0;
                else if (menu_q && menu_sel_q == 2'(z))
                    zone_led_out[z] <= pend_q[z] | blink_q;
                else if (menu_q)
                    zone_led_out[z] <= pend_q[z];
                else
                    zone_led_out[z] <= dis_q[z];
            end
        end
    endgenerate

    // AHB-Lite slave, zero wait states, always OKAY
    assign ap_valid = hsel_in && hready_in && htrans_in[1];

    always_comb
    begin
        rd_mux = panel_pkg::RDATA_ZERO;
        unique case (haddr_in[panel_pkg::ADDR_W-1:0])
            panel_pkg::ADDR_CTRL: rd_mux[panel_pkg::CTRL_LEVEL2_BIT] = level2_q;
            panel_pkg::ADDR_TIMES: rd_mux[$bits(panel_pkg::times_t)-1:0] = stored_q;
            panel_pkg::ADDR_STATUS:
            begin
                rd_mux[panel_pkg::ST_PROG_BIT] = prog_q;
                rd_mux[panel_pkg::ST_MENU_BIT] = menu_q;
                rd_mux[panel_pkg::ST_SEL_LSB +: 2] = menu_sel_q;
                rd_mux[panel_pkg::ST_DIS_LSB +: panel_pkg::NUM_ITEMS] = dis_q;
                rd_mux[panel_pkg::ST_SEQ_LSB +: 2] = seq_q;
                rd_mux[panel_pkg::ST_DISCH_BIT] = discharge_out;
                rd_mux[panel_pkg::ST_LOCK_BIT] = locked;
            end
            default: rd_mux = panel_pkg::RDATA_ZERO;
        endcase
        if (haddr_in[31:panel_pkg::ADDR_W] != '0)
            rd_mux = panel_pkg::RDATA_ZERO;
    end

    always_ff @(posedge sys_clk_in)
    begin
        if (srst_in)
        begin
            wr_pend_q <= 1'b0;
            wr_addr_q <= '0;
            hrdata_out <= panel_pkg::RDATA_ZERO;
            hreadyout_out <= 1'b1;
            hresp_out <= 1'b0;
        end
        else
        begin
            hreadyout_out <= 1'b1;
            hresp_out <= 1'b0;
            wr_pend_q <= ap_valid && hwrite_in && (haddr_in[31:panel_pkg::ADDR_W] == '0);
            if (ap_valid)
                wr_addr_q <= haddr_in[panel_pkg::ADDR_W-1:0];
            if (ap_valid && !hwrite_in)
                hrdata_out <= rd_mux;
        end
    end

    always_ff @(posedge sys_clk_in)
    begin
        if (srst_in)
            level2_q <= 1'b0;
        else if (wr_pend_q && wr_addr_q == panel_pkg::ADDR_CTRL)
            level2_q <= hwdata_in[panel_pkg::CTRL_LEVEL2_BIT];
    end
endmodule

/* tb/panel_settings_monitor.sv */
`timescale 1ns/100ps
module panel_settings_monitor #(
    parameter int unsigned TICK_CYCLES = 20
) (
    // Clock and reset
    input wire logic sys_clk_in,
    input wire logic srst_in,
    // Watched inputs
    input wire logic [2:0] zone_fire_in,
    input wire logic program_switch_in,
    // Watched outputs
    input wire logic [2:0] zone_alarm_out,
    input wire logic first_siren_enable_out,
    input wire logic discharge_out,
    input wire logic reset_accept_out,
    input wire logic display_on_out,
    input wire logic [1:0] display_sel_out,
    input wire logic [6:0] display_value_out,
    input wire logic disable_led_out,
    input wire logic [2:0] zone_led_out
);
    default clocking @(posedge sys_clk_in); endclocking
    default disable iff (srst_in);
    localparam int unsigned UNIT = 5 * TICK_CYCLES;
    logic [31:0] dis_len_q;
    // Length of the current discharge pulse
    always_ff @(posedge sys_clk_in)
        if (srst_in || !discharge_out)
            dis_len_q <= 32'h0;
        else
            dis_len_q <= dis_len_q + 32'h1;
    sequence dis_end_s;
        $fell(discharge_out);
    endsequence
    sequence sel_held_s;
        display_on_out && $past(display_on_out) && display_sel_out == $past(display_sel_out);
    endsequence
    disch_len_a: assert property (dis_end_s |-> dis_len_q != 32'h0 && dis_len_q % UNIT == 32'h0)
        else $error("discharge length wrong");
    entry_a: assert property ($rose(display_on_out) |-> $past(program_switch_in, 3))
        else $error("display lit without switch on");
    leave_a: assert property ($fell(display_on_out) |-> !$past(program_switch_in, 2))
        else $error("programming left with switch on");
    range_a: assert property (display_on_out |-> display_sel_out != 2'b10 && display_value_out
        <= (display_sel_out == 2'b00 ? panel_pkg::DUR_MAX : display_sel_out == 2'b01 ? 7'h3C : 7'h1E))
        else $error("time outside range");
    sel_order_a: assert property (display_on_out && $past(display_on_out) && display_sel_out != $past(display_sel_out)
        |-> {$past(display_sel_out), display_sel_out} inside {4'b0001, 4'b0111, 4'b1100})
        else $error("selection order wrong");
    one_step_a: assert property (sel_held_s |-> (display_value_out - $past(display_value_out)) inside {7'h00, 7'h01, 7'h7F})
        else $error("value jumped");
    alarm_mask_a: assert property ((zone_alarm_out & ~($past(zone_fire_in) | $past(zone_fire_in, 2)
        | $past(zone_fire_in, 3))) == 3'h0)
        else $error("alarm without fire");
    lock_a: assert property (discharge_out && $past(discharge_out) |-> !reset_accept_out)
        else $error("reset accepted during discharge");
    accept_pulse_a: assert property (reset_accept_out |=> !reset_accept_out)
        else $error("accept pulse too long");
    power_up_a: assert property ($fell(srst_in) |-> first_siren_enable_out && zone_led_out == 3'h0 && !disable_led_out)
        else $error("reset left disablements");
endmodule
bind panel_settings panel_settings_monitor #(.TICK_CYCLES(TICK_CYCLES)) mon (.*);

/* tb/panel_operator.sv */
`timescale 1ns/100ps
module panel_operator (
    // Clock and reset
    input wire logic sys_clk_in,
    input wire logic srst_in,
    // Press request
    input wire logic go_in,
    input wire logic [2:0] btn_in,
    // Buttons and state
    output logic [4:0] press_out,
    output logic busy_out
);
    logic [3:0] cnt_q;
    // Four cycles held, six released per press
    always_ff @(posedge sys_clk_in)
        if (srst_in)
        begin
            cnt_q <= 4'h0;
            press_out <= 5'h00;
        end
        else if (go_in && cnt_q == 4'h0)
        begin
            cnt_q <= 4'hA;
            press_out <= 5'h01 << btn_in;
        end
        else if (cnt_q != 4'h0)
        begin
            cnt_q <= cnt_q - 4'h1;
            if (cnt_q == 4'h7)
                press_out <= 5'h00;
        end
    assign busy_out = cnt_q != 4'h0;
endmodule

/* tb/testbench.sv */
`timescale 1ns/100ps
module testbench;
    localparam int unsigned TICK = 20;
    // Rows: button, expected selection, expected value
    localparam logic [11:0] ROWS [13] = '{12'h003, 12'h202, 12'h201, 12'h200, 12'h200, 12'h001, 12'h4BC,
        12'h0BC, 12'h2BB, 12'h59E, 12'h19E, 12'h39D, 12'h401};
    logic sys_clk_in = 1'b0;
    logic srst_in = 1'b1;
    logic hsel_in = 1'b0;
    logic [31:0] haddr_in = 32'h0;
    logic [1:0] htrans_in = 2'h0;
    logic hwrite_in = 1'b0;
    logic [31:0] hwdata_in = 32'h0;
    logic prog_sw = 1'b0;
    logic go = 1'b0;
    logic [2:0] btn = 3'h0;
    logic [2:0] zone_fire = 3'h0;
    logic activated = 1'b0;
    logic [31:0] hrdata_out, rd;
    logic [4:0] press;
    logic [2:0] zone_alarm_out, zone_led_out;
    logic [1:0] display_sel_out;
    logic [6:0] display_value_out;
    logic busy, hreadyout_out, hresp_out, first_siren_enable_out, discharge_out, reset_accept_out;
    logic display_on_out, disable_led_out, siren_fault_led_out;
    int err_total = 0;
    int check_count = 0;
    int acc_n = 0;
    int cyc = 0;
    int acc0, w, d;
    initial forever #5 sys_clk_in = ~sys_clk_in;
    panel_settings #(.TICK_CYCLES(TICK)) dut (.sys_clk_in, .srst_in, .hsel_in, .haddr_in, .htrans_in, .hwrite_in,
        .hsize_in(3'h2), .hwdata_in, .hready_in(hreadyout_out), .hrdata_out, .hreadyout_out, .hresp_out,
        .program_switch_in(prog_sw), .buzzer_mute_button_in(press[0]), .siren_mute_button_in(press[1]),
        .scroll_button_in(press[2]), .toggle_button_in(press[3]), .reset_button_in(press[4]),
        .zone_fire_in(zone_fire), .activated_in(activated), .zone_alarm_out, .first_siren_enable_out, .discharge_out,
        .reset_accept_out, .display_on_out, .display_sel_out, .display_value_out, .disable_led_out, .zone_led_out,
        .siren_fault_led_out);
    panel_operator op (.sys_clk_in, .srst_in, .go_in(go), .btn_in(btn), .press_out(press), .busy_out(busy));
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            err_total++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic tally_and_finish;
        $display("checks %0d errors %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic bus_xfer(input logic [7:0] a, input logic wr, input logic [31:0] wd);
        hsel_in <= 1'b1;
        haddr_in <= {24'h0, a};
        hwrite_in <= wr;
        htrans_in <= 2'h2;
        do @(posedge sys_clk_in); while (hreadyout_out !== 1'b1);
        htrans_in <= 2'h0;
        hwdata_in <= wd;
        do @(posedge sys_clk_in); while (hreadyout_out !== 1'b1);
        rd = hrdata_out;
    endtask
    task automatic rd_status;
        bus_xfer(panel_pkg::ADDR_STATUS, 1'b0, 32'h0);
    endtask
    task automatic push(input logic [2:0] b);
        go <= 1'b1;
        btn <= b;
        @(posedge sys_clk_in);
        go <= 1'b0;
        @(posedge sys_clk_in);
        while (busy) @(posedge sys_clk_in);
    endtask
    always @(posedge sys_clk_in)
    begin
        acc_n <= acc_n + int'(reset_accept_out === 1'b1);
        cyc <= cyc + 1;
        if (cyc == 60000)
        begin
            err_total++;
            tally_and_finish();
        end
    end
    initial
    begin
        repeat (20) @(posedge sys_clk_in);
        srst_in <= 1'b0;
        @(posedge sys_clk_in);
        check({first_siren_enable_out, disable_led_out, zone_led_out}, 5'h10);
        bus_xfer(panel_pkg::ADDR_TIMES, 1'b0, 32'h0);
        check(rd, 32'h0000_179E);
        bus_xfer(8'h40, 1'b0, 32'h0);
        check(rd, 32'h0);
        $display("reset test done");
        prog_sw <= 1'b1;
        repeat (8) @(posedge sys_clk_in);
        check({display_on_out, display_sel_out, display_value_out}, 10'h202);
        foreach (ROWS[i])
        begin
            push(ROWS[i][11:9]);
            check({display_sel_out, display_value_out}, ROWS[i][8:0]);
        end
        prog_sw <= 1'b0;
        repeat (8) @(posedge sys_clk_in);
        bus_xfer(panel_pkg::ADDR_TIMES, 1'b0, 32'h0);
        check({display_on_out, rd}, 33'h0_0000_0F7D);
        $display("programming test done");
        push(3);
        rd_status();
        check(rd[1], 1'b0);
        bus_xfer(panel_pkg::ADDR_CTRL, 1'b1, 32'h1);
        push(3);
        rd_status();
        check(rd[3:1], 3'b001);
        repeat (3) push(2);
        rd_status();
        check(rd[3:1], 3'b111);
        push(3);
        check(siren_fault_led_out, 1'b1);
        repeat (TICK) @(posedge sys_clk_in);
        check(siren_fault_led_out, 1'b1);
        push(2);
        push(3);
        push(4);
        rd_status();
        check(rd[7:1], 7'h48);
        check({disable_led_out, zone_led_out, first_siren_enable_out}, 5'b10010);
        zone_fire <= 3'b011;
        repeat (6) @(posedge sys_clk_in);
        check(zone_alarm_out, 3'b010);
        push(3);
        rd_status();
        check(rd[1], 1'b0);
        zone_fire <= 3'b000;
        repeat (6) @(posedge sys_clk_in);
        push(3);
        zone_fire <= 3'b100;
        repeat (8) @(posedge sys_clk_in);
        rd_status();
        check(rd[1], 1'b0);
        zone_fire <= 3'b000;
        $display("menu test done");
        activated <= 1'b1;
        d = 0;
        while (!discharge_out)
        begin
            @(posedge sys_clk_in);
            d++;
        end
        w = 0;
        while (discharge_out)
        begin
            @(posedge sys_clk_in);
            w++;
        end
        check(d >= 59 * TICK, 1'b1);
        check(w, 5 * TICK);
        acc0 = acc_n;
        push(4);
        rd_status();
        check({acc_n == acc0, rd[11]}, 2'b11);
        repeat (29 * 60 * TICK + 40) @(posedge sys_clk_in);
        rd_status();
        check(rd[11:8], 4'h2);
        activated <= 1'b0;
        repeat (4) @(posedge sys_clk_in);
        activated <= 1'b1;
        repeat (40) @(posedge sys_clk_in);
        push(4);
        check(acc_n, acc0 + 1);
        repeat (62 * TICK) @(posedge sys_clk_in);
        check(discharge_out, 1'b0);
        $display("sequencer test done");
        tally_and_finish();
    end
endmodule
